// >>> pkg/ssc_defs.svh
// constants for the synchronous serial clock and transmit block
// assumes byte-wide register port and a 200 MHz ref_clk acting as the high-frequency clock
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH

// register offsets
`define SSC_ADDR_CTRL 8'h20
`define SSC_ADDR_STAT 8'h21
`define SSC_ADDR_DATA 8'h22

// serial_control_reg fields
`define SSC_CR_RUN 7
`define SSC_CR_FSTOP 6
`define SSC_CR_MODE_HI 5
`define SSC_CR_MODE_LO 4
`define SSC_CR_ORDER 3
`define SSC_CR_CLK_HI 2
`define SSC_CR_CLK_LO 0

// serial_state_reg fields
`define SSC_SR_ACTIVE 7
`define SSC_SR_SHIFT 6
`define SSC_SR_TXE 5
`define SSC_SR_RXF 4
`define SSC_SR_TX_UNDERRUN_ERROR_FLAG 3
`define SSC_SR_RXERR 2

// codes
`define SSC_CLK_EXT 3'h7
`define SSC_CLK_SLOWEST 3'h0
`define SSC_MODE_TX 2'h0
`define SSC_ORDER_LSB 1'h1

// counts
`define SSC_BITS_PER_BYTE 4'h8
`define SSC_LAST_BIT 4'h7
`define SSC_FIRST_BIT 4'h1
// half period of fc/2^n is 2^(n-1) ref cycles; codes 1..6 give n = 9 - code
`define SSC_FC_HALF_EXP 4'h8
`define SSC_FC4096_MASK 11'h7ff
// fs/16 half period is 8 fs rising edges
`define SSC_FS_HALF_LAST 3'h7

`endif

// >>> pkg/ssc_pkg.sv
// types and shift helpers for the synchronous serial clock and transmit block
// assumes ssc_defs.svh is visible on the include path
`include "ssc_defs.svh"

package ssc_pkg;

    typedef enum logic [1:0] {
        SSC_IDLE = 2'b00,
        SSC_SHIFT = 2'b01,
        SSC_WAIT = 2'b10
    } ssc_state_t;

    typedef struct packed {
        ssc_state_t state;
        logic sck;
        logic so;
        logic [7:0] shreg;
        logic [7:0] tbuf;
        logic [3:0] bitcnt;
        logic run;
        logic [1:0] mode;
        logic order;
        logic [2:0] clksel;
        logic shifting;
        logic txempty;
        logic tx_underrun_error_flag;
        logic loaded;
        logic irq_pend;
        logic irq;
        logic [7:0] rdata;
        logic sck_d;
        logic fs_d;
    } ssc_regs_t;

    typedef struct packed {
        logic [10:0] cnt;
        logic [2:0] fcnt;
    } ssc_div_t;

    function automatic logic ssc_out_bit(input logic [7:0] d, input logic order);
        return (order == `SSC_ORDER_LSB) ? d[0] : d[7];
    endfunction

    function automatic logic [7:0] ssc_shift(input logic [7:0] d, input logic order);
        return (order == `SSC_ORDER_LSB) ? {1'b1, d[7:1]} : {d[6:0], 1'b1};
    endfunction

endpackage

// >>> verilog/ssc_sync.sv
// two-flop synchroniser for pin-level inputs
// assumes inputs are asynchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none

module ssc_sync #(
    parameter int WIDTH = 2
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] stage_r;

    // pins idle high, so reset to ones avoids a false falling edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_r <= '1;
            stage_r <= '1;
        end else begin
            meta_r <= async_in;
            stage_r <= meta_r;
        end
    end

    assign sync_out = stage_r;

endmodule // ssc_sync

`default_nettype wire

// >>> verilog/ssc_clkdiv.sv
// serial clock half-period tick generator
// assumes ref_clk is the high-frequency clock; fs_rise is a synchronised one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
`include "ssc_defs.svh"

module ssc_clkdiv (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [2:0] clksel,
    input wire logic slow_divider_select,
    input wire logic low_speed_mode,
    input wire logic fs_rise,
    output logic tick
);
    ssc_pkg::ssc_div_t st_r;
    ssc_pkg::ssc_div_t st_nxt;
    logic use_fs;
    logic [10:0] mask;

    // free-running divider: restart latency after a wait is at most one serial period
    always_comb begin
        use_fs = (clksel == `SSC_CLK_SLOWEST) && (slow_divider_select || low_speed_mode);
        if (clksel == `SSC_CLK_SLOWEST) begin
            mask = `SSC_FC4096_MASK;
        end else begin
            mask = 11'((11'h1 << (`SSC_FC_HALF_EXP - {1'b0, clksel})) - 11'h1);
        end
        st_nxt = st_r;
        st_nxt.cnt = st_r.cnt + 11'h1;
        if (fs_rise) begin
            st_nxt.fcnt = st_r.fcnt + 3'h1;
        end
        if (clksel == `SSC_CLK_EXT) begin
            tick = 1'b0;
        end else if (use_fs) begin
            tick = fs_rise && (st_r.fcnt == `SSC_FS_HALF_LAST); // see RULE_04
        end else if (low_speed_mode) begin
            // reserved codes in low-speed operation: clock stays parked
            tick = 1'b0;
        end else begin
            tick = (st_r.cnt & mask) == mask; // see RULE_04
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule // ssc_clkdiv

`default_nettype wire

// >>> verilog/ssc_top.sv
// synchronous serial interface: clock source, bit order and transmit-only transfer
// assumes a byte-wide register port on ref_clk; pins are asynchronous and pass a synchroniser
//
// Notes on behaviour
// RULE_01: internal clock codes drive the serial clock pin, idle high.
// RULE_02: internal clock parks high when no next byte is buffered.
// RULE_03: clock resumes within one serial period after the buffer write.
// RULE_04: code 0 gives fc/4096 or fs/16; codes 1-6 give fc/256 to fc/8.
// RULE_05: code 111 takes the serial clock from the pin as input.
// RULE_06: external clock phases must each last at least four fc periods.
// RULE_07: transmit bits change on falling edges, receive samples on rising.
// RULE_08: one bit-order control; 0 sends MSB first, 1 sends LSB first.
// RULE_09: software changes bit order only while transfer is inactive.
// RULE_10: transfer mode 00 selects transmit-only operation.
// RULE_11: writing the transmit buffer clears the buffer-empty flag.
// RULE_12: transfer-active flag sets on a serial clock falling edge after run.
// RULE_13: shift flag is high from first to eighth falling edge of a byte.
// RULE_14: buffer-empty sets on next rising edge after load, interrupt next fall.
// RULE_15: internal clock never starts without a byte in the buffer.
// RULE_16: internal clock loads the buffer within one period, then clocks.
// RULE_17: external clock loads the buffer on the first received falling edge.
// RULE_18: internal clock waits high after a byte; buffer write restarts it.
// RULE_19: a byte written during a byte follows it with no gap.
// RULE_20: with external clock, software refills before the next byte starts.
// RULE_21: starting a byte with empty buffer sets underrun, then interrupts.
// RULE_22: force-stop halts at once, resets run, status, buffers, reads zero.
// RULE_23: error flag clears only by writing zero or force-stop.
// RULE_24: clearing run finishes the current byte, then goes idle high.
// RULE_25: interrupt request is a one-cycle pulse per event.
// RULE_26: external serial clock is synchronised and edge-detected on ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_defs.svh"

module ssc_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic slow_divider_select,
    input wire logic low_speed_mode,
    input wire logic low_freq_clock,
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe_n,
    output logic serial_out_pin,
    output logic serial_irq
);
    ssc_pkg::ssc_regs_t st_r;
    ssc_pkg::ssc_regs_t st_nxt;
    logic [1:0] pins_sync;
    logic sck_sync;
    logic fs_sync;
    logic fs_rise;
    logic div_tick;
    logic ext_mode;
    logic start_ok;
    logic fall_ev;
    logic rise_ev;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_data;

    ssc_sync #(
        .WIDTH(2)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in({serial_clock_pin_i, low_freq_clock}),
        .sync_out(pins_sync)
    );

    assign sck_sync = pins_sync[1];
    assign fs_sync = pins_sync[0];
    assign fs_rise = fs_sync && !st_r.fs_d;

    ssc_clkdiv u_div (
        .ref_clk(ref_clk),
        .rst(rst),
        .clksel(st_r.clksel),
        .slow_divider_select(slow_divider_select),
        .low_speed_mode(low_speed_mode),
        .fs_rise(fs_rise),
        .tick(div_tick)
    );

    assign ext_mode = st_r.clksel == `SSC_CLK_EXT; // see RULE_05
    assign start_ok = st_r.run && (st_r.mode == `SSC_MODE_TX); // see RULE_10
    assign wr_ctrl = reg_wr && (reg_addr == `SSC_ADDR_CTRL);
    assign wr_stat = reg_wr && (reg_addr == `SSC_ADDR_STAT);
    assign wr_data = reg_wr && (reg_addr == `SSC_ADDR_DATA);

    // edges seen on ref_clk; external phases of four fc periods are always caught
    always_comb begin
        if (ext_mode) begin
            fall_ev = st_r.sck_d && !sck_sync; // see RULE_26, RULE_06
            rise_ev = !st_r.sck_d && sck_sync && (st_r.state == ssc_pkg::SSC_SHIFT);
        end else begin
            // the internal clock only falls when a byte can go out; otherwise it parks high
            fall_ev = div_tick && st_r.sck
                && ((st_r.state == ssc_pkg::SSC_SHIFT) || (start_ok && !st_r.txempty)); // see RULE_02, RULE_15
            rise_ev = div_tick && !st_r.sck && (st_r.state == ssc_pkg::SSC_SHIFT);
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.irq = 1'b0;
        st_nxt.sck_d = sck_sync;
        st_nxt.fs_d = fs_sync;
        st_nxt.rdata = 8'h00;

        // register reads; the receive buffer is not built here and reads zero
        if (reg_rd) begin
            case (reg_addr)
                `SSC_ADDR_CTRL: begin
                    st_nxt.rdata = {st_r.run, 1'b0, st_r.mode, st_r.order, st_r.clksel};
                end
                `SSC_ADDR_STAT: begin
                    st_nxt.rdata = {st_r.state != ssc_pkg::SSC_IDLE, st_r.shifting, st_r.txempty,
                                    1'b0, st_r.tx_underrun_error_flag, 3'h0};
                end
                default: begin
                    st_nxt.rdata = 8'h00;
                end
            endcase
        end

        // register writes first, so that hardware set events below win
        if (wr_ctrl) begin
            st_nxt.run = reg_wdata[`SSC_CR_RUN];
            st_nxt.mode = reg_wdata[`SSC_CR_MODE_HI:`SSC_CR_MODE_LO];
            st_nxt.order = reg_wdata[`SSC_CR_ORDER]; // see RULE_08, RULE_09
            st_nxt.clksel = reg_wdata[`SSC_CR_CLK_HI:`SSC_CR_CLK_LO];
        end
        if (wr_stat && !reg_wdata[`SSC_SR_TX_UNDERRUN_ERROR_FLAG]) begin
            st_nxt.tx_underrun_error_flag = 1'b0; // see RULE_23
        end
        // a write while the buffer still holds a byte is dropped
        if (wr_data && st_r.txempty) begin
            st_nxt.tbuf = reg_wdata;
            st_nxt.txempty = 1'b0; // see RULE_11, RULE_19
        end

        // park the data line a cycle after the last rise, never on the sampling edge itself
        if (st_r.state == ssc_pkg::SSC_IDLE) begin
            st_nxt.so = 1'b1; // see RULE_24
        end

        if (fall_ev) begin
            if (st_r.irq_pend) begin
                st_nxt.irq = 1'b1; // see RULE_14, RULE_25
                st_nxt.irq_pend = 1'b0;
            end
            if (st_r.state == ssc_pkg::SSC_SHIFT) begin
                st_nxt.bitcnt = st_r.bitcnt + 4'h1;
                st_nxt.so = ssc_pkg::ssc_out_bit(st_r.shreg, st_r.order); // see RULE_07
                st_nxt.shreg = ssc_pkg::ssc_shift(st_r.shreg, st_r.order);
                if (st_r.bitcnt == `SSC_LAST_BIT) begin
                    st_nxt.shifting = 1'b0; // see RULE_13
                end
            end else if (start_ok) begin
                st_nxt.state = ssc_pkg::SSC_SHIFT; // see RULE_12
                st_nxt.bitcnt = `SSC_FIRST_BIT;
                st_nxt.shifting = 1'b1; // see RULE_13
                if (!st_r.txempty) begin
                    // load and first bit on the same falling edge
                    st_nxt.so = ssc_pkg::ssc_out_bit(st_r.tbuf, st_r.order); // see RULE_08
                    st_nxt.shreg = ssc_pkg::ssc_shift(st_r.tbuf, st_r.order); // see RULE_16, RULE_17
                    st_nxt.loaded = 1'b1;
                end else begin
                    // only reachable with external clock: the far side ignored the empty flag
                    st_nxt.tx_underrun_error_flag = 1'b1; // see RULE_21, RULE_20
                    st_nxt.irq_pend = 1'b1;
                    st_nxt.shreg = 8'hff;
                end
            end
            if (!ext_mode) begin
                st_nxt.sck = 1'b0;
            end
        end

        if (rise_ev) begin
            if (!ext_mode) begin
                st_nxt.sck = 1'b1;
            end
            if (st_r.loaded) begin
                st_nxt.txempty = 1'b1; // see RULE_14
                st_nxt.loaded = 1'b0;
                st_nxt.irq_pend = 1'b1;
            end
            if (st_r.bitcnt == `SSC_BITS_PER_BYTE) begin
                st_nxt.bitcnt = 4'h0;
                if (st_nxt.run) begin
                    st_nxt.state = ssc_pkg::SSC_WAIT; // see RULE_18, RULE_03
                end else begin
                    st_nxt.state = ssc_pkg::SSC_IDLE; // see RULE_24
                end
            end
        end

        // run dropped while parked between bytes: nothing left to finish
        if ((st_r.state == ssc_pkg::SSC_WAIT) && !st_nxt.run && !fall_ev) begin
            st_nxt.state = ssc_pkg::SSC_IDLE; // see RULE_24
            st_nxt.so = 1'b1;
        end

        if (st_nxt.tx_underrun_error_flag) begin
            st_nxt.so = 1'b1; // see RULE_21
        end

        // force-stop overrides everything in the same cycle
        if (wr_ctrl && reg_wdata[`SSC_CR_FSTOP]) begin
            st_nxt.state = ssc_pkg::SSC_IDLE; // see RULE_22
            st_nxt.run = 1'b0;
            st_nxt.sck = 1'b1;
            st_nxt.so = 1'b1;
            st_nxt.tbuf = 8'h00;
            st_nxt.shreg = 8'hff;
            st_nxt.bitcnt = 4'h0;
            st_nxt.shifting = 1'b0;
            st_nxt.txempty = 1'b1;
            st_nxt.tx_underrun_error_flag = 1'b0; // see RULE_23
            st_nxt.loaded = 1'b0;
            st_nxt.irq_pend = 1'b0;
            st_nxt.irq = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
            st_r.sck <= 1'b1;
            st_r.so <= 1'b1;
            st_r.shreg <= 8'hff;
            st_r.txempty <= 1'b1;
            st_r.sck_d <= 1'b1;
            st_r.fs_d <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign serial_clock_pin_o = st_r.sck; // see RULE_01
    assign serial_clock_pin_oe_n = ext_mode; // see RULE_01, RULE_05
    assign serial_out_pin = st_r.so;
    assign serial_irq = st_r.irq;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_fstop_wr;
        wr_ctrl && reg_wdata[`SSC_CR_FSTOP];
    endsequence

    sequence s_stopped;
        !st_r.run && st_r.txempty && !st_r.tx_underrun_error_flag && (st_r.state == ssc_pkg::SSC_IDLE) && st_r.sck;
    endsequence

    property p_sck_idle_high;
        (!ext_mode && (st_r.state != ssc_pkg::SSC_SHIFT)) |-> serial_clock_pin_o;
    endproperty
    a_sck_idle_high: assert property (p_sck_idle_high) else $error("serial clock low outside a byte"); // see RULE_01

    property p_pin_dir;
        (ext_mode && $past(ext_mode)) |-> serial_clock_pin_oe_n && $stable(serial_clock_pin_o);
    endproperty
    a_pin_dir: assert property (p_pin_dir) else $error("serial clock pin driven in external mode"); // see RULE_05

    property p_write_clears_empty;
        (wr_data && st_r.txempty && !(wr_ctrl && reg_wdata[`SSC_CR_FSTOP])) |=> !st_r.txempty;
    endproperty
    a_write_clears_empty: assert property (p_write_clears_empty) else $error("buffer write kept empty flag"); // see RULE_11

    property p_irq_pulse;
        serial_irq |=> !serial_irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than one cycle"); // see RULE_25

    property p_force_stop;
        s_fstop_wr |=> s_stopped ##1 (st_r.state == ssc_pkg::SSC_IDLE);
    endproperty
    a_force_stop: assert property (p_force_stop) else $error("force-stop did not reinitialise"); // see RULE_22

    property p_err_write_one;
        (st_r.tx_underrun_error_flag && wr_stat && reg_wdata[`SSC_SR_TX_UNDERRUN_ERROR_FLAG] && !wr_ctrl) |=> st_r.tx_underrun_error_flag;
    endproperty
    a_err_write_one: assert property (p_err_write_one) else $error("error flag cleared by writing one"); // see RULE_23

    property p_active_on_fall;
        $rose(st_r.state == ssc_pkg::SSC_SHIFT) |-> $past(fall_ev);
    endproperty
    a_active_on_fall: assert property (p_active_on_fall) else $error("transfer started off a falling edge"); // see RULE_12

    property p_no_start_empty;
        (fall_ev && !ext_mode && (st_r.state != ssc_pkg::SSC_SHIFT)) |-> !st_r.txempty;
    endproperty
    a_no_start_empty: assert property (p_no_start_empty) else $error("internal clock started without data"); // see RULE_15

    property p_err_out_high;
        st_r.tx_underrun_error_flag |-> serial_out_pin;
    endproperty
    a_err_out_high: assert property (p_err_out_high) else $error("serial out not high during underrun"); // see RULE_21

    property p_shift_flag;
        (fall_ev && (st_r.state == ssc_pkg::SSC_SHIFT) && (st_r.bitcnt == `SSC_LAST_BIT)
            && !(wr_ctrl && reg_wdata[`SSC_CR_FSTOP])) |=> !st_r.shifting && (st_r.bitcnt == `SSC_BITS_PER_BYTE);
    endproperty
    a_shift_flag: assert property (p_shift_flag) else $error("shift flag not cleared at eighth fall"); // see RULE_13

    sequence s_wait_ready;
        (st_r.state == ssc_pkg::SSC_WAIT) && start_ok && !st_r.txempty && !ext_mode;
    endsequence

    sequence s_clock_low_shift;
        (st_r.state == ssc_pkg::SSC_SHIFT) && !st_r.sck;
    endsequence

    // a parked clock with a refilled buffer must fall at the very next half-period tick
    property p_resume;
        (s_wait_ready ##0 (div_tick && !wr_ctrl)) |=> s_clock_low_shift;
    endproperty
    a_resume: assert property (p_resume) else $error("clock did not resume after buffer write"); // see RULE_18

    property p_empty_on_rise;
        (rise_ev && st_r.loaded && !wr_ctrl) |=> st_r.txempty;
    endproperty
    a_empty_on_rise: assert property (p_empty_on_rise) else $error("empty flag not set at rise"); // see RULE_14

    property p_underrun;
        (ext_mode && fall_ev && start_ok && st_r.txempty && (st_r.state != ssc_pkg::SSC_SHIFT) && !wr_ctrl)
            |=> st_r.tx_underrun_error_flag && serial_out_pin;
    endproperty
    a_underrun: assert property (p_underrun) else $error("underrun not flagged at start"); // see RULE_21

    property p_so_idle_high;
        ((st_r.state == ssc_pkg::SSC_IDLE) && $past(st_r.state == ssc_pkg::SSC_IDLE)) |-> serial_out_pin;
    endproperty
    a_so_idle_high: assert property (p_so_idle_high) else $error("serial out not high while idle"); // see RULE_24

endmodule // ssc_top

`default_nettype wire

// >>> tb/ssc_ext_dev.sv
// far-side serial device: samples data on serial clock rises and can drive the clock
// assumes the bench resolves the shared clock pin and feeds the level back on sck
`timescale 1ns/1ps
`default_nettype none

module ssc_ext_dev (
    input wire logic sck,
    input wire logic sdata,
    output logic sck_drv
);
    logic [7:0] sh;
    int nb;
    logic [7:0] got[$];

    initial begin
        sck_drv = 1'b1;
        nb = 0;
    end

    // bits arrive first-to-last, so the byte is assembled first bit on top
    always @(posedge sck) begin
        sh = {sh[6:0], sdata};
        nb++;
        if (nb == 8) begin
            got.push_back(sh);
            nb = 0;
        end
    end

    task automatic flush();
        nb = 0;
        got.delete();
    endtask

    // clock stands high between frames; half must not drop under 20 ns
    task automatic pulses(input int n, input int half);
        repeat (n) begin
            #half sck_drv = 1'b0;
            #half sck_drv = 1'b1;
        end
    endtask

endmodule // ssc_ext_dev
`default_nettype wire

// >>> tb/tb_sync_serial_clock_and_transmit.sv
// self-checking bench for the serial clock and transmit block
// assumes ssc_defs.svh on the include path and the far-side model ssc_ext_dev
`timescale 1ns/1ps
`default_nettype none
`include "ssc_defs.svh"

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value at %0t: got %0h want %0h", $time, g, e); end end

module tb_sync_serial_clock_and_transmit;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic slow_sel = 1'b0;
    logic low_spd = 1'b0;
    logic fs_clk = 1'b0;
    logic [7:0] reg_rdata;
    logic sck_o, sck_oe_n, so, irq, dev_sck;
    logic irq_d = 1'b0;
    logic [7:0] s;
    int error_cnt = 0;
    int n_checks = 0;
    int irq_cnt = 0;
    int irq_long = 0;
    int cyc = 0;
    int n;
    time t0;
    wire sck_pin;

    // open pin: whoever is enabled sets the level
    assign sck_pin = sck_oe_n ? dev_sck : sck_o;

    always #2.5 ref_clk = ~ref_clk;
    always #50 fs_clk = ~fs_clk;

    ssc_top DUT (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .slow_divider_select(slow_sel), .low_speed_mode(low_spd), .low_freq_clock(fs_clk),
        .serial_clock_pin_i(sck_pin), .serial_clock_pin_o(sck_o),
        .serial_clock_pin_oe_n(sck_oe_n), .serial_out_pin(so), .serial_irq(irq)
    );

    ssc_ext_dev u_dev (.sck(sck_pin), .sdata(so), .sck_drv(dev_sck));

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        irq_d <= irq;
        if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
        if (irq === 1'b1 && irq_d === 1'b1) irq_long <= irq_long + 1;
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            error_cnt++;
            $display("wrong value at %0t: run took too long", $time);
            conclude();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // counts polled cycles until the pin has gone high then low
    task automatic wait_fall(input int lim, output int m);
        m = 0;
        while (sck_pin !== 1'b1 && m < lim) begin
            @(posedge ref_clk);
            #1 m++;
        end
        while (sck_pin !== 1'b0 && m < lim) begin
            @(posedge ref_clk);
            #1 m++;
        end
        if (m >= lim) begin
            error_cnt++;
            $display("wrong value at %0t: no serial clock fall", $time);
        end
    endtask

    task automatic wait_rx(input int k, input int lim);
        int m;
        m = 0;
        while (u_dev.got.size() < k && m < lim) begin
            @(posedge ref_clk);
            #1 m++;
        end
        if (m >= lim) begin
            error_cnt++;
            $display("wrong value at %0t: byte not received", $time);
        end
    endtask

    function automatic logic [7:0] rev8(input logic [7:0] d);
        for (int i = 0; i < 8; i++) rev8[i] = d[7 - i];
    endfunction

    // one byte on an internal clock code; per is the serial period in ref cycles
    task automatic tx_int(input logic [2:0] c, input logic o, input logic [7:0] d, input int per, input int k);
        int m;
        wr(`SSC_ADDR_DATA, d);
        wr(`SSC_ADDR_CTRL, {4'h8, o, c});
        wait_fall(per + 4, m);
        wait_fall(per + 4, m);
        `CHK(m, per)
        wait_rx(k, 9 * per);
        `CHK(u_dev.got[k - 1], o ? rev8(d) : d)
        `CHK(irq_cnt, k)
        wr(`SSC_ADDR_CTRL, {4'h0, o, c});
        rd(`SSC_ADDR_STAT, s);
        `CHK(s, 8'h20)
    endtask

    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1 u_dev.flush();
        `CHK({sck_pin, sck_oe_n, so}, 3'b101)
        rd(`SSC_ADDR_STAT, s);
        `CHK(s, 8'h20)
        rd(8'h23, s);
        `CHK(s, 8'h00)
        wr(`SSC_ADDR_CTRL, 8'h86);
        repeat (40) @(posedge ref_clk);
        #1;
        `CHK(sck_pin, 1'b1)
        wr(`SSC_ADDR_DATA, 8'ha5);
        wait_fall(12, n);
        t0 = $time;
        rd(`SSC_ADDR_STAT, s);
        `CHK(s[7:6], 2'b11)
        n = 0;
        while (s[5] !== 1'b1 && n < 20) begin
            rd(`SSC_ADDR_STAT, s);
            n++;
        end
        `CHK(s[5], 1'b1)
        wr(`SSC_ADDR_DATA, 8'h3c);
        wait_rx(2, 200);
        `CHK(($time - t0) < 640, 1'b1)
        `CHK(u_dev.got[0], 8'ha5)
        `CHK(u_dev.got[1], 8'h3c)
        `CHK(irq_cnt, 2)
        repeat (40) @(posedge ref_clk);
        #1;
        `CHK(sck_pin, 1'b1)
        rd(`SSC_ADDR_STAT, s);
        `CHK(s, 8'ha0)
        wr(`SSC_ADDR_DATA, 8'h81);
        wait_fall(12, n);
        `CHK(n <= 9, 1'b1)
        wr(`SSC_ADDR_CTRL, 8'h06);
        wait_rx(3, 100);
        `CHK(u_dev.got[2], 8'h81)
        repeat (4) @(posedge ref_clk);
        #1;
        `CHK({sck_pin, so}, 2'b11)
        // code 0 three times: fast source, slow-select source, then low-speed operation
        for (int c = 0; c < 8; c++) begin
            slow_sel <= (c == 6);
            low_spd <= (c == 7);
            tx_int(c >= 6 ? 3'h0 : 3'(c), c[0], 8'h35 + 8'(c),
                   c >= 6 ? 320 : (c == 0 ? 4096 : 1 << (9 - c)), 4 + c);
        end
        slow_sel <= 1'b0;
        // low-speed operation leaves codes 1..6 without a clock
        wr(`SSC_ADDR_DATA, 8'h77);
        wr(`SSC_ADDR_CTRL, 8'h81);
        repeat (300) @(posedge ref_clk);
        #1;
        `CHK(sck_pin, 1'b1)
        low_spd <= 1'b0;
        wr(`SSC_ADDR_CTRL, 8'h47);
        wr(`SSC_ADDR_DATA, 8'hc3);
        wr(`SSC_ADDR_DATA, 8'h99);
        wr(`SSC_ADDR_CTRL, 8'h87);
        #1;
        `CHK(sck_oe_n, 1'b1)
        u_dev.pulses(8, 40);
        wait_rx(12, 20);
        `CHK(u_dev.got[11], 8'hc3)
        // no refill before the next frame, on purpose
        u_dev.pulses(8, 40);
        wait_rx(13, 20);
        `CHK(u_dev.got[12], 8'hff)
        `CHK(irq_cnt, 13)
        wr(`SSC_ADDR_STAT, 8'h08);
        wr(`SSC_ADDR_CTRL, 8'h07);
        rd(`SSC_ADDR_STAT, s);
        `CHK(s[3], 1'b1)
        wr(`SSC_ADDR_STAT, 8'h00);
        rd(`SSC_ADDR_STAT, s);
        `CHK(s[3], 1'b0)
        wr(`SSC_ADDR_CTRL, 8'h06);
        wr(`SSC_ADDR_DATA, 8'h5a);
        wr(`SSC_ADDR_CTRL, 8'h86);
        wait_fall(12, n);
        wr(`SSC_ADDR_CTRL, 8'hc6);
        rd(`SSC_ADDR_CTRL, s);
        `CHK(s, 8'h06)
        rd(`SSC_ADDR_STAT, s);
        `CHK(s, 8'h20)
        repeat (60) @(posedge ref_clk);
        #1;
        `CHK({sck_pin, so, u_dev.got.size() == 13}, 3'b111)
        `CHK(irq_long, 0)
        conclude();
    end

endmodule // tb_sync_serial_clock_and_transmit
`default_nettype wire
